// File: dsmh_pkg.sv
// Package: offsets, field positions, reset values and carriers of the status block
package dsmh_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MISSED = 8'h04;
    localparam logic [7:0] OFF_RX_STAT = 8'h08;
    localparam logic [7:0] OFF_TX_STAT = 8'h0c;
    localparam logic [7:0] OFF_HASH = 8'h10;

    // Reset values
    localparam logic [13:0] CTRL_MAXLEN_RST = 14'h05ee;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Receive status word fields
    localparam int RX_OVR_BIT = 0;
    localparam int RX_CRC_BIT = 1;
    localparam int RX_DRIB_BIT = 2;
    localparam int RX_LONG_BIT = 7;
    localparam int RX_MCAST_BIT = 10;
    localparam int RX_LEN_LSB = 16;
    localparam int RX_LEN_W = 14;

    // Transmit status word fields
    localparam int TX_DEFER_BIT = 0;
    localparam int TX_CC_LSB = 3;
    localparam int TX_CC_W = 4;
    localparam int TX_HB_BIT = 7;
    localparam int TX_EXC_BIT = 8;
    localparam int TX_LATE_BIT = 9;
    localparam int TX_NOCAR_BIT = 10;
    localparam int TX_LOSS_BIT = 11;

    // Hash register fields
    localparam int HASH_BITS = 9;
    localparam int HASH_VALID_BIT = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Counts and CRC constants
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [2:0] ADDR_BYTES = 3'h6;
    localparam logic [3:0] COLL_MAX = 4'hf;
    localparam logic [15:0] MISSED_MAX = 16'hffff;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [13:0] len;
        logic crc_err;
        logic dribble;
        logic overrun;
    } dsmh_rx_info_type;

    typedef struct packed {
        logic deferred;
        logic excess;
        logic late;
        logic no_carrier;
        logic loss_carrier;
        logic hb_fail;
    } dsmh_tx_info_type;

endpackage

// File: dsmh_crc_byte.sv
// One byte step of the reflected CRC-32, least significant bit first
`timescale 1ns/100ps
module dsmh_crc_byte (
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data,
    output logic [31:0] crc_out
);

    always_comb begin
        crc_out = crc_in;
        for (int b = 0; b < 8; b++) begin
            crc_out = {1'b0, crc_out[31:1]}
                ^ (((crc_out[0] ^ data[b]) == 1'b1) ? dsmh_pkg::CRC_POLY : 32'h0000_0000);
        end
    end

endmodule

// File: dsmh_top.sv
// Descriptor status words, missed frame counter and multicast hash, AHB-Lite slave
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module dsmh_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_end,
    input wire dsmh_pkg::dsmh_rx_info_type rx_info,
    input wire logic dst_valid,
    input wire logic dst_first,
    input wire logic [7:0] dst_byte,
    input wire logic missed_pulse,
    input wire logic tx_start,
    input wire logic tx_coll,
    input wire logic tx_end,
    input wire dsmh_pkg::dsmh_tx_info_type tx_info,
    output logic [31:0] rx_status_word,
    output logic rx_status_valid,
    output logic [31:0] tx_status_word,
    output logic tx_status_valid,
    output logic [8:0] hash_index,
    output logic hash_valid,
    output logic [15:0] missed_frame_counter
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic [13:0] max_len_r;
    logic [15:0] missed_r;
    logic [15:0] missed_nxt;
    logic [31:0] rx_word_r;
    logic [31:0] tx_word_r;
    logic [8:0] hash_r;
    logic hash_seen_r;
    logic wr_pend_r;
    logic [7:0] wa_r;
    logic [31:0] hrdata_r;

    wire logic bus_take = hsel & htrans[1] & hready;
    wire logic [7:0] ra = haddr[7:0];
    wire logic rd_take = bus_take & ~hwrite;
    wire logic rd_clr = rd_take & (ra == dsmh_pkg::OFF_MISSED);
    wire logic wr_ctrl = wr_pend_r & (wa_r == dsmh_pkg::OFF_CTRL);
    wire logic [31:0] hash_word = {15'h0000, hash_seen_r, 7'h00, hash_r};
    wire logic [31:0] rd_word =
        (ra == dsmh_pkg::OFF_CTRL) ? {18'h00000, max_len_r} :
        (ra == dsmh_pkg::OFF_MISSED) ? {16'h0000, missed_r} :
        (ra == dsmh_pkg::OFF_RX_STAT) ? rx_word_r :
        (ra == dsmh_pkg::OFF_TX_STAT) ? tx_word_r :
        (ra == dsmh_pkg::OFF_HASH) ? hash_word : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wa_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= bus_take & hwrite;
            wa_r <= bus_take ? ra : wa_r;
            hrdata_r <= rd_take ? rd_word : hrdata_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            max_len_r <= dsmh_pkg::CTRL_MAXLEN_RST;
        end else if (wr_ctrl) begin
            max_len_r <= hwdata[13:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Missed frame counter, cleared by read, a drop in the read cycle is kept
    wire logic [15:0] missed_inc = (missed_r == dsmh_pkg::MISSED_MAX) ? missed_r : missed_r + 16'h0001;

    assign missed_nxt = missed_pulse ? (rd_clr ? 16'h0001 : missed_inc) :
        (rd_clr ? 16'h0000 : missed_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            missed_r <= 16'h0000;
        end else begin
            missed_r <= missed_nxt;
        end
    end

    assign missed_frame_counter = missed_r;

    ////////////////////////////////////////////////////////////////////////////
    // Multicast hash over the destination address
    logic [31:0] crc_r;
    logic [2:0] byte_cnt_r;
    logic mc_r;
    logic hash_valid_r;
    logic [31:0] crc_out;
    logic [31:0] crc_be;
    logic [8:0] hash_nxt;

    wire logic in_addr = (byte_cnt_r != 3'h0) & (byte_cnt_r < dsmh_pkg::ADDR_BYTES);
    wire logic accept = dst_valid & (dst_first | in_addr);
    wire logic [31:0] crc_in = dst_first ? dsmh_pkg::CRC_INIT : crc_r;
    wire logic [2:0] cnt_nxt = dst_first ? 3'h1 : byte_cnt_r + 3'h1;
    wire logic addr_done = accept & (cnt_nxt == dsmh_pkg::ADDR_BYTES);

    dsmh_crc_byte u_crc (
        .crc_in(crc_in),
        .data(dst_byte),
        .crc_out(crc_out)
    );

    for (genvar i = 0; i < 32; i++) begin : g_rev
        assign crc_be[i] = crc_out[31 - i];
    end
    for (genvar i = 0; i < dsmh_pkg::HASH_BITS; i++) begin : g_idx
        assign hash_nxt[i] = crc_be[31 - i];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_r <= dsmh_pkg::CRC_INIT;
            byte_cnt_r <= 3'h0;
            mc_r <= 1'b0;
        end else if (accept) begin
            crc_r <= crc_out;
            byte_cnt_r <= cnt_nxt;
            mc_r <= dst_first ? dst_byte[0] : mc_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hash_r <= 9'h000;
            hash_valid_r <= 1'b0;
            hash_seen_r <= 1'b0;
        end else begin
            hash_r <= addr_done ? hash_nxt : hash_r;
            hash_valid_r <= addr_done;
            hash_seen_r <= hash_seen_r | addr_done;
        end
    end

    assign hash_index = hash_r;
    assign hash_valid = hash_valid_r;

    ////////////////////////////////////////////////////////////////////////////
    // Receive status word
    logic [31:0] rx_word_nxt;
    logic rx_valid_r;

    always_comb begin
        rx_word_nxt = dsmh_pkg::WORD_RST;
        rx_word_nxt[dsmh_pkg::RX_LEN_LSB +: dsmh_pkg::RX_LEN_W] = rx_info.len;
        rx_word_nxt[dsmh_pkg::RX_MCAST_BIT] = mc_r;
        rx_word_nxt[dsmh_pkg::RX_CRC_BIT] = rx_info.crc_err;
        rx_word_nxt[dsmh_pkg::RX_DRIB_BIT] = rx_info.dribble;
        rx_word_nxt[dsmh_pkg::RX_LONG_BIT] = rx_info.len > max_len_r;
        rx_word_nxt[dsmh_pkg::RX_OVR_BIT] = rx_info.overrun;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_word_r <= dsmh_pkg::WORD_RST;
            rx_valid_r <= 1'b0;
        end else begin
            rx_word_r <= rx_end ? rx_word_nxt : rx_word_r;
            rx_valid_r <= rx_end;
        end
    end

    assign rx_status_word = rx_word_r;
    assign rx_status_valid = rx_valid_r;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit status word with collision count
    logic [3:0] coll_r;
    logic [31:0] tx_word_nxt;
    logic tx_valid_r;

    wire logic [3:0] coll_inc = (coll_r == dsmh_pkg::COLL_MAX) ? coll_r : coll_r + 4'h1;
    wire logic [3:0] coll_cur = tx_coll ? coll_inc : coll_r;
    wire logic [3:0] coll_nxt = tx_start ? {3'h0, tx_coll} : coll_cur;

    always_comb begin
        tx_word_nxt = dsmh_pkg::WORD_RST;
        tx_word_nxt[dsmh_pkg::TX_DEFER_BIT] = tx_info.deferred;
        tx_word_nxt[dsmh_pkg::TX_CC_LSB +: dsmh_pkg::TX_CC_W] = coll_cur;
        tx_word_nxt[dsmh_pkg::TX_EXC_BIT] = tx_info.excess;
        tx_word_nxt[dsmh_pkg::TX_LATE_BIT] = tx_info.late;
        tx_word_nxt[dsmh_pkg::TX_LOSS_BIT] = tx_info.loss_carrier;
        tx_word_nxt[dsmh_pkg::TX_NOCAR_BIT] = tx_info.no_carrier;
        tx_word_nxt[dsmh_pkg::TX_HB_BIT] = tx_info.hb_fail;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coll_r <= 4'h0;
            tx_word_r <= dsmh_pkg::WORD_RST;
            tx_valid_r <= 1'b0;
        end else begin
            coll_r <= coll_nxt;
            tx_word_r <= tx_end ? tx_word_nxt : tx_word_r;
            tx_valid_r <= tx_end;
        end
    end

    assign tx_status_word = tx_word_r;
    assign tx_status_valid = tx_valid_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire logic [13:0] rx_len_in = rx_info.len;
    wire logic rx_crc_in = rx_info.crc_err;
    wire logic rx_drib_in = rx_info.dribble;
    wire logic rx_ovr_in = rx_info.overrun;
    wire logic tx_def_in = tx_info.deferred;
    wire logic tx_exc_in = tx_info.excess;
    wire logic tx_late_in = tx_info.late;
    wire logic tx_loss_in = tx_info.loss_carrier;
    wire logic tx_nocar_in = tx_info.no_carrier;
    wire logic tx_hb_in = tx_info.hb_fail;

    sequence rx_done_s;
        rx_end ##1 rx_status_valid;
    endsequence

    sequence tx_done_s;
        tx_end ##1 tx_status_valid;
    endsequence

    sequence three_coll_s;
        tx_start & ~tx_coll ##1 (tx_coll & ~tx_start)[*3] ##1 (tx_end & ~tx_coll & ~tx_start);
    endsequence

    sequence six_bytes_s;
        (dst_valid & dst_first) ##1 (dst_valid & ~dst_first)[*5];
    endsequence

    rx_len_a: assert property (rx_end |=> rx_status_valid
        && rx_status_word[29:16] == $past(rx_len_in))
        else $error("rx length field wrong");
    rx_mcast_a: assert property (dst_valid & dst_first ##1 (~dst_first & ~rx_end)[*6]
        ##1 (rx_end & ~dst_first) |=> rx_status_word[10] == $past(dst_byte[0], 8))
        else $error("multicast flag wrong");
    rx_err_a: assert property (rx_done_s |-> rx_status_word[1] == $past(rx_crc_in)
        && rx_status_word[2] == $past(rx_drib_in))
        else $error("crc or dribble flag wrong");
    rx_long_a: assert property (rx_done_s |-> rx_status_word[7]
        == ($past(rx_len_in) > $past(max_len_r)))
        else $error("too long flag wrong");
    rx_ovr_a: assert property (rx_done_s |-> rx_status_word[0] == $past(rx_ovr_in))
        else $error("overrun flag wrong");
    tx_defer_a: assert property (tx_done_s |-> tx_status_word[0] == $past(tx_def_in))
        else $error("deferred flag wrong");
    tx_coll_a: assert property (three_coll_s |=> tx_status_word[6:3] == 4'h3)
        else $error("collision count wrong");
    tx_excess_a: assert property (tx_done_s |-> tx_status_word[8] == $past(tx_exc_in))
        else $error("excess collision flag wrong");
    tx_late_a: assert property (tx_done_s |-> tx_status_word[9] == $past(tx_late_in)
        && tx_status_word[11] == $past(tx_loss_in))
        else $error("late or carrier loss flag wrong");
    tx_nocar_a: assert property (tx_done_s |-> tx_status_word[10] == $past(tx_nocar_in))
        else $error("no carrier flag wrong");
    tx_hb_a: assert property (tx_done_s |-> tx_status_word[7] == $past(tx_hb_in))
        else $error("heartbeat flag wrong");
    missed_cnt_a: assert property (missed_pulse & ~rd_clr & missed_r != 16'hffff
        |=> missed_r == $past(missed_r) + 16'h0001)
        else $error("missed counter did not count");
    hash_six_a: assert property (six_bytes_s |=> hash_valid)
        else $error("hash not ready after six bytes");
    hash_bits_a: assert property (hash_valid |-> hash_index == crc_r[8:0]
        && byte_cnt_r == 3'h6)
        else $error("hash index order wrong");

endmodule

// File: dsmh_host_model.sv
// Host driver model: AHB-Lite master and descriptor helpers
`timescale 1ns/100ps
module dsmh_host_model (
    input wire logic hclk,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Single word transfer, each phase held until hready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        hwdata <= ~wd;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Bytes sent by one transmit descriptor
    function automatic logic [11:0] bytes_sent(input logic [31:0] tx_control_word);
        return {1'b0, tx_control_word[10:0]} + {1'b0, tx_control_word[21:11]};
    endfunction
endmodule

// File: test_descriptor_status_and_mcast_hash.sv
// Testbench: random frames through the status block, checked against computed words
`timescale 1ns/100ps
module test_descriptor_status_and_mcast_hash;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic rx_end = 1'b0;
    dsmh_pkg::dsmh_rx_info_type rx_info = '0;
    logic dst_valid = 1'b0;
    logic dst_first = 1'b0;
    logic [7:0] dst_byte = 8'h00;
    logic missed_pulse = 1'b0;
    logic tx_start = 1'b0;
    logic tx_coll = 1'b0;
    logic tx_end = 1'b0;
    dsmh_pkg::dsmh_tx_info_type tx_info = '0;
    logic [31:0] rx_status_word;
    logic rx_status_valid;
    logic [31:0] tx_status_word;
    logic tx_status_valid;
    logic [8:0] hash_index;
    logic hash_valid;
    logic [15:0] missed_frame_counter;
    int fail_count = 0;
    int n_checks = 0;
    int n;
    logic [13:0] max_len;
    logic [31:0] rdat;
    logic [31:0] wdat;
    logic [47:0] addr;

    always #4 hclk = ~hclk;

    dsmh_top u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .rx_end(rx_end),
        .rx_info(rx_info), .dst_valid(dst_valid), .dst_first(dst_first),
        .dst_byte(dst_byte), .missed_pulse(missed_pulse), .tx_start(tx_start),
        .tx_coll(tx_coll), .tx_end(tx_end), .tx_info(tx_info),
        .rx_status_word(rx_status_word), .rx_status_valid(rx_status_valid),
        .tx_status_word(tx_status_word), .tx_status_valid(tx_status_valid),
        .hash_index(hash_index), .hash_valid(hash_valid),
        .missed_frame_counter(missed_frame_counter)
    );

    dsmh_host_model u_host (
        .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Compare, register read, verdict
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        u_host.xfer(1'b0, a, 32'h0, rdat);
        check(name, rdat, exp);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task stop_test;
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reflected CRC over six bytes, low bit first
    function automatic logic [8:0] hash_exp(input logic [47:0] a);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 48; i++) begin
            c = (c >> 1) ^ ((c[0] ^ a[i]) ? 32'hedb88320 : 32'h0);
        end
        return c[8:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Frame drivers
    task automatic send_addr(input logic [47:0] a);
        for (int i = 0; i < 6; i++) begin
            @(posedge hclk);
            dst_valid <= 1'b1;
            dst_first <= (i == 0);
            dst_byte <= a[8*i +: 8];
        end
        @(posedge hclk);
        dst_valid <= 1'b0;
        #1;
        check("hash_valid", {31'h0, hash_valid}, 32'h1);
        check("hash_index", {23'h0, hash_index}, {23'h0, hash_exp(a)});
    endtask

    task automatic send_rx(input logic [13:0] len, input logic [2:0] f, input logic mc);
        logic [31:0] w;
        w = {2'b00, len, 5'h0, mc, 2'b00, (len > max_len), 4'h0, f[1], f[2], f[0]};
        @(posedge hclk);
        rx_end <= 1'b1;
        rx_info <= dsmh_pkg::dsmh_rx_info_type'({len, f});
        @(posedge hclk);
        rx_end <= 1'b0;
        rx_info <= dsmh_pkg::dsmh_rx_info_type'(~{len, f});
        #1;
        check("rx_valid", {31'h0, rx_status_valid}, 32'h1);
        check("rx_word", rx_status_word, w);
        reg_rd(dsmh_pkg::OFF_RX_STAT, w, "rx_reg");
    endtask

    task automatic send_tx(input int ncoll, input logic [5:0] f);
        logic [31:0] w;
        logic [3:0] c;
        c = (ncoll > 15) ? 4'hf : 4'(ncoll);
        w = {20'h0, f[1], f[2], f[3], f[4], f[0], c, 2'b00, f[5]};
        @(posedge hclk);
        tx_start <= 1'b1;
        for (int i = 0; i < ncoll; i++) begin
            @(posedge hclk);
            tx_start <= 1'b0;
            tx_coll <= 1'b1;
        end
        @(posedge hclk);
        tx_start <= 1'b0;
        tx_coll <= 1'b0;
        tx_end <= 1'b1;
        tx_info <= dsmh_pkg::dsmh_tx_info_type'(f);
        @(posedge hclk);
        tx_end <= 1'b0;
        #1;
        check("tx_valid", {31'h0, tx_status_valid}, 32'h1);
        check("tx_word", tx_status_word, w);
        reg_rd(dsmh_pkg::OFF_TX_STAT, w, "tx_reg");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h7657));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        reg_rd(dsmh_pkg::OFF_CTRL, {18'h0, dsmh_pkg::CTRL_MAXLEN_RST}, "ctrl_rst");
        reg_rd(dsmh_pkg::OFF_MISSED, 32'h0, "missed_rst");
        reg_rd(dsmh_pkg::OFF_RX_STAT, 32'h0, "rx_rst");
        reg_rd(dsmh_pkg::OFF_TX_STAT, 32'h0, "tx_rst");
        reg_rd(dsmh_pkg::OFF_HASH, 32'h0, "hash_rst");
        reg_rd(8'h14, 32'h0, "unmapped");
        wdat = $urandom & 32'hffff_dfff;
        max_len = wdat[13:0];
        u_host.xfer(1'b1, dsmh_pkg::OFF_CTRL, wdat, rdat);
        reg_rd(dsmh_pkg::OFF_CTRL, {18'h0, max_len}, "ctrl");
        for (int i = 0; i < 24; i++) begin
            addr = {16'($urandom), $urandom};
            if (i < 2) begin
                addr[0] = i[0];
            end
            send_addr(addr);
            n = (i == 0) ? max_len : (i == 1) ? max_len + 1 : $urandom;
            send_rx(14'(n), 3'($urandom), addr[0]);
        end
        reg_rd(dsmh_pkg::OFF_HASH, {15'h0, 1'b1, 7'h0, hash_exp(addr)}, "hash_reg");
        for (int i = 0; i < 20; i++) begin
            n = (i < 3) ? 14 + i : (i == 3) ? 3 : $urandom % 19;
            send_tx(n, 6'($urandom));
            wdat = {10'h0, 11'($urandom), 11'($urandom)};
            check("bytes_sent", {20'h0, u_host.bytes_sent(wdat)},
                32'(wdat[10:0]) + 32'(wdat[21:11]));
        end
        n = 1 + $urandom % 40;
        repeat (n) begin
            @(posedge hclk);
            missed_pulse <= 1'b1;
        end
        @(posedge hclk);
        missed_pulse <= 1'b0;
        #1;
        check("missed", {16'h0, missed_frame_counter}, 32'(n));
        reg_rd(dsmh_pkg::OFF_MISSED, 32'(n), "missed_reg");
        reg_rd(dsmh_pkg::OFF_MISSED, 32'h0, "missed_clr");
        stop_test;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        stop_test;
    end
endmodule
